// >>> verilog/adcc_map.vh
`ifndef ADCC_MAP_VH
`define ADCC_MAP_VH
// ----------------------------------------
// Register byte offsets (printed offsets are not all multiples of four: index * 4)
// ----------------------------------------
`define ADCC_IDX_ISOLATE     8'hae
`define ADCC_IDX_CTRL        8'hb1
`define ADCC_IDX_RES_HI      8'hb2
`define ADCC_IDX_RES_LO      8'hb3
`define ADCC_ADDR_ISOLATE    10'h2b8
`define ADCC_ADDR_CTRL       10'h2c4
`define ADCC_ADDR_RES_HI     10'h2c8
`define ADCC_ADDR_RES_LO     10'h2cc
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ADCC_CTRL_POWER      7
`define ADCC_CTRL_GO         6
`define ADCC_CTRL_DONE       5
`define ADCC_CTRL_GATE       4
`define ADCC_LO_CKS1         6
`define ADCC_LO_CKS0         4
// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define ADCC_RST_CTRL        8'h00
`define ADCC_RST_ISOLATE     5'h00
`define ADCC_RST_CKS         2'h0
`define ADCC_NUM_CHAN        5
`define ADCC_STEPS           16
`define ADCC_CLK_PER_STEP    4
`define ADCC_CONV_CLKS       (`ADCC_STEPS * `ADCC_CLK_PER_STEP)
`define ADCC_RESP_OKAY       2'h0
`define ADCC_RESP_SLVERR     2'h2
`endif

// >>> verilog/adcc_clkdiv.v
`timescale 1ns/1ps
`include "adcc_map.vh"
module adcc_clkdiv (
	// Clock and reset
	input  wire       aclk,
	input  wire       aresetn,
	// Control
	input  wire       run,
	input  wire [1:0] sel,
	// Converter clock enable
	output reg        tick
);
	reg [3:0] cnt_r;
	reg [3:0] lim;

	// Divider limit per selection
	always @* begin
		case (sel)
			2'h0:    lim = 4'hf;
			2'h1:    lim = 4'h7;
			2'h2:    lim = 4'h0;
			2'h3:    lim = 4'h1;
			default: lim = 4'hf;
		endcase
	end

	// Count up to one pulse per divided period
	always @(posedge aclk) begin
		if (!aresetn || !run) begin
			cnt_r <= 4'h0;
			tick  <= 1'b0;
		end else if (cnt_r >= lim) begin
			cnt_r <= 4'h0;
			tick  <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 4'h1;
			tick  <= 1'b0;
		end
	end
endmodule

// >>> verilog/adcc_top.v
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "adcc_map.vh"
module adcc_top (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address
	input  wire [31:0] s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [31:0] s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Analog core
	output reg         core_power,
	output reg  [4:0]  chan_connect,
	output reg  [4:0]  pin_isolate,
	output reg         core_sample,
	output reg         core_step,
	input  wire [11:0] core_result
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg        power_r;
	reg        go_r;
	reg        done_r;
	reg        gate_r;
	reg [2:0]  sel_r;
	reg [1:0]  cks_r;
	reg [4:0]  iso_r;
	reg [11:0] result_r;
	reg        busy_r;
	reg [5:0]  clk_cnt_r;
	reg        aw_held_r;
	reg [9:0]  aw_addr_r;
	reg        w_held_r;
	reg [31:0] w_data_r;
	reg [3:0]  w_strb_r;

	wire       tick;
	wire       do_write;
	wire [9:0] wr_addr;
	wire       start;
	wire       finish;
	reg  [7:0] ctrl_rd;
	reg  [7:0] lo_rd;

	// Map a word address to whether it is one of our registers
	function mapped;
		input [9:0] a;
		begin
			mapped = (a == `ADCC_ADDR_ISOLATE) || (a == `ADCC_ADDR_CTRL) ||
				(a == `ADCC_ADDR_RES_HI) || (a == `ADCC_ADDR_RES_LO);
		end
	endfunction

	// ----------------------------------------
	// Write channel capture
	// ----------------------------------------
	// Address and data are taken in either order, then the write fires
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
	assign do_write      = aw_held_r && w_held_r && !s_axi_bvalid;
	assign wr_addr       = aw_addr_r;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r    <= 1'b0;
			aw_addr_r    <= 10'h000;
			w_held_r     <= 1'b0;
			w_data_r     <= 32'h0000_0000;
			w_strb_r     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `ADCC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= {s_axi_awaddr[9:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held_r    <= 1'b0;
				w_held_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped(wr_addr) ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Conversion control
	// ----------------------------------------
	wire wr_ctrl = do_write && wr_addr == `ADCC_ADDR_CTRL && w_strb_r[0];
	wire wr_lo   = do_write && wr_addr == `ADCC_ADDR_RES_LO && w_strb_r[0];
	wire wr_iso  = do_write && wr_addr == `ADCC_ADDR_ISOLATE && w_strb_r[0];

	// Start needs power and an idle converter
	assign start  = go_r && power_r && !busy_r;
	assign finish = busy_r && tick && clk_cnt_r == `ADCC_CONV_CLKS - 1;

	always @(posedge aclk) begin
		if (!aresetn) begin
			power_r <= 1'b0;
			go_r    <= 1'b0;
			done_r  <= 1'b0;
			gate_r  <= 1'b0;
			sel_r   <= 3'h0;
			cks_r   <= `ADCC_RST_CKS;
			iso_r   <= `ADCC_RST_ISOLATE;
			busy_r  <= 1'b0;
			clk_cnt_r <= 6'h00;
		end else begin
			if (wr_ctrl) begin
				power_r <= w_data_r[`ADCC_CTRL_POWER];
				gate_r  <= w_data_r[`ADCC_CTRL_GATE];
				sel_r   <= w_data_r[2:0];
				go_r    <= w_data_r[`ADCC_CTRL_GO];
				if (w_data_r[`ADCC_CTRL_GO] && !busy_r)
					done_r <= 1'b0;
				else
					done_r <= w_data_r[`ADCC_CTRL_DONE];
			end
			if (wr_lo)
				cks_r <= {w_data_r[`ADCC_LO_CKS1], w_data_r[`ADCC_LO_CKS0]};
			if (wr_iso)
				iso_r <= w_data_r[4:0];
			if (start) begin
				busy_r    <= 1'b1;
				clk_cnt_r <= 6'h00;
				done_r    <= 1'b0;
			end else if (busy_r && !power_r) begin
				busy_r <= 1'b0; // Power loss aborts
				go_r   <= 1'b0;
			end else if (finish) begin
				busy_r <= 1'b0;
				done_r <= 1'b1;
				go_r   <= 1'b0;
			end else if (busy_r && tick) begin
				clk_cnt_r <= clk_cnt_r + 6'h01;
			end
		end
	end

	// Result capture, no reset
	always @(posedge aclk) begin
		if (finish)
			result_r <= core_result;
	end

	// Converter clock enable
	adcc_clkdiv u_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (busy_r),
		.sel     (cks_r),
		.tick    (tick)
	);

	// ----------------------------------------
	// Analog side outputs
	// ----------------------------------------
	integer i;
	always @(posedge aclk) begin
		if (!aresetn) begin
			core_power   <= 1'b0;
			chan_connect <= 5'h00;
			pin_isolate  <= 5'h00;
			core_sample  <= 1'b0;
			core_step    <= 1'b0;
		end else begin
			core_power  <= power_r;
			pin_isolate <= iso_r;
			core_sample <= start;
			core_step   <= busy_r && tick && clk_cnt_r[1:0] == 2'h3;
			for (i = 0; i < `ADCC_NUM_CHAN; i = i + 1)
				chan_connect[i] <= gate_r && sel_r == i;
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	always @* begin
		ctrl_rd = {power_r, go_r, done_r, gate_r, 1'b0, sel_r};
		lo_rd   = {1'b0, cks_r[1], 1'b0, cks_r[0], result_r[3:0]};
	end

	assign s_axi_arready = !s_axi_rvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `ADCC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `ADCC_RESP_OKAY;
			case ({s_axi_araddr[9:2], 2'b00})
				`ADCC_ADDR_ISOLATE: s_axi_rdata <= {27'h000_0000, iso_r};
				`ADCC_ADDR_CTRL:    s_axi_rdata <= {24'h00_0000, ctrl_rd};
				`ADCC_ADDR_RES_HI:  s_axi_rdata <= {24'h00_0000, result_r[11:4]};
				`ADCC_ADDR_RES_LO:  s_axi_rdata <= {24'h00_0000, lo_rd};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `ADCC_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// >>> test/adcc_top_sva.sv
`timescale 1ns/1ps
module adcc_top_sva (
	input wire       aclk,
	input wire       aresetn,
	input wire       s_axi_awready,
	input wire       s_axi_bvalid,
	input wire       s_axi_bready,
	input wire       s_axi_arvalid,
	input wire       s_axi_arready,
	input wire       s_axi_rvalid,
	input wire       s_axi_rready,
	input wire       core_power,
	input wire [4:0] chan_connect,
	input wire       core_sample,
	input wire       core_step
);
	default clocking dc @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Handshake and conversion phases
	sequence s_ar; s_axi_arvalid && s_axi_arready; endsequence
	sequence s_step; core_step ##1 !core_step [*3]; endsequence
	sequence s_start; core_sample ##1 !core_sample [*8]; endsequence
	a_chan_onehot: assert property ($onehot0(chan_connect))
		else $error("more than one input connected");
	a_sample_power: assert property (core_sample |-> core_power)
		else $error("conversion started unpowered");
	a_step_gap: assert property (core_step |-> s_step)
		else $error("steps closer than four clocks");
	a_start_once: assert property (core_sample |-> s_start)
		else $error("conversion restarted");
	a_read_answer: assert property (s_ar |=> s_axi_rvalid)
		else $error("read not answered");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read answer dropped");
	a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write taken while answering");
endmodule
bind adcc_top adcc_top_sva adcc_top_sva_i (.*);

// >>> test/adcc_core_model.sv
`timescale 1ns/1ps
module adcc_core_model (
	input wire        aclk,
	input wire        core_power,
	input wire [4:0]  chan_connect,
	input wire [59:0] levels,
	output reg [11:0] core_result
);
	integer n;
	initial core_result = 12'h000;
	// Connected input as binary code, else a changing pattern
	always @(posedge aclk) begin
		core_result <= ~core_result;
		for (n = 0; n < 5; n = n + 1)
			if (core_power && chan_connect[n]) core_result <= levels[n*12 +: 12];
	end
endmodule

// >>> test/adc_control_and_result_regs_tb_top.sv
`timescale 1ns/1ps
`include "adcc_map.vh"
module adc_control_and_result_regs_tb_top;
	reg         aclk = 0, aresetn = 0;
	reg  [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, d;
	reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	reg         s_axi_arvalid = 0, s_axi_rready = 0;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire        core_power, core_sample, core_step;
	wire [4:0]  chan_connect, pin_isolate;
	wire [11:0] core_result;
	reg  [59:0] lvl = 0;
	reg  [1:0]  r;
	integer     errors = 0, n_compared = 0, seed = 83844, i, ch, nsteps = 0, gap = 0, last, cyc = 0;
	adcc_top adcc_top_i (.*, .s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .s_axi_wstrb(4'hf));
	adcc_core_model adcc_core_model_i (.*, .levels(lvl));
	initial forever #25 aclk = ~aclk;
	// Step count and spacing
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (core_sample) nsteps <= 0;
		else if (core_step) nsteps <= nsteps + 1;
		if (core_step) gap <= cyc - last;
		if (core_step) last <= cyc;
	end
	function integer divf(input integer s);
		divf = s == 0 ? 16 : s == 1 ? 8 : s == 2 ? 1 : 2;
	endfunction
	task chk(input [63:0] n, input [31:0] s, input [31:0] e); begin
		n_compared = n_compared + 1;
		if (s !== e) begin
			errors = errors + 1;
			$display("Error %0s expected %h seen %h", n, e, s);
		end
	end endtask
	// Bus write: address and data each held until its ready is sampled at a rising edge, bready until bvalid is
	task wr(input [9:0] a, input [7:0] v);
		reg pa, pw, pb;
		integer k;
		begin
			s_axi_awaddr <= a; s_axi_wdata <= v;
			s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
			pa = 1; pw = 1; pb = 1;
			for (k = 0; k < 100 && pb; k = k + 1) begin
				@(posedge aclk);
				if (pa && s_axi_awready) begin
					pa = 0;
					s_axi_awvalid <= 0;
				end
				if (pw && s_axi_wready) begin
					pw = 0;
					s_axi_wvalid <= 0;
				end
				if (s_axi_bvalid) begin
					pb = 0;
					s_axi_bready <= 0;
				end
			end
			if (pb) errors = errors + 1;
			@(posedge aclk);
		end
	endtask
	// Bus read: data taken at the edge where rvalid is sampled high
	task rd(input [9:0] a);
		reg pr;
		integer k;
		begin
			s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
			pr = 1;
			for (k = 0; k < 100 && pr; k = k + 1) begin
				@(posedge aclk);
				if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
				if (s_axi_rvalid) begin
					pr = 0;
					d = s_axi_rdata;
					r = s_axi_rresp;
					s_axi_rready <= 0;
				end
			end
			if (pr) errors = errors + 1;
			@(posedge aclk);
		end
	endtask
	task report_and_stop; begin
		$display("compared %0d mismatched %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	end endtask
	initial begin
		repeat (20000) @(posedge aclk);
		errors = errors + 1;
		report_and_stop;
	end
	// Reset values, unmapped access, then one conversion per clock choice
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		rd(`ADCC_ADDR_CTRL); chk("ctrl", d, 0);
		rd(`ADCC_ADDR_RES_LO); chk("cks", d & 32'h0000_0050, 0);
		rd(`ADCC_ADDR_ISOLATE); chk("iso", d, 0);
		rd(10'h3f0); chk("resp", r, 2); chk("rdat", d, 0);
		$display("reset test done");
		wr(`ADCC_ADDR_CTRL, 8'h80);
		repeat (2000) @(negedge aclk);
		chk("pwr", core_power, 1);
		for (i = 0; i < 4; i = i + 1) begin
			ch = {$random(seed)} % 5;
			lvl[ch*12 +: 12] <= i == 0 ? 0 : i == 1 ? 12'hfff : $random(seed);
			wr(`ADCC_ADDR_ISOLATE, 1 << ch);
			wr(`ADCC_ADDR_RES_LO, {i[1], 1'b0, i[0], 4'h0});
			wr(`ADCC_ADDR_CTRL, 8'h90 | ch);
			wr(`ADCC_ADDR_CTRL, 8'hd0 | ch);
			rd(`ADCC_ADDR_CTRL); chk("busy", d[6:5], 2'h2);
			chk("conn", chan_connect, 1 << ch);
			chk("pin", pin_isolate, 1 << ch);
			d = 0;
			repeat (3000) if (!d[5]) rd(`ADCC_ADDR_CTRL);
			chk("done", d[7:4], 4'hb);
			chk("steps", nsteps, 16);
			chk("gap", gap, 4 * divf(i));
			wr(`ADCC_ADDR_RES_HI, ~lvl[ch*12+4 +: 8]);
			wr(`ADCC_ADDR_RES_LO, {i[1], 1'b0, i[0], ~lvl[ch*12 +: 4]});
			rd(`ADCC_ADDR_RES_HI); chk("hi", d, lvl[ch*12+4 +: 8]);
			rd(`ADCC_ADDR_RES_LO); chk("lo", d, {i[1], 1'b0, i[0], lvl[ch*12 +: 4]});
			$display("conversion test %0d done", i);
		end
		wr(`ADCC_ADDR_CTRL, 8'h80 | ch);
		@(negedge aclk); chk("gate", chan_connect, 0);
		wr(`ADCC_ADDR_CTRL, 8'h00);
		wr(`ADCC_ADDR_CTRL, 8'h40);
		repeat (200) @(negedge aclk);
		chk("idle", nsteps, 16);
		chk("off", core_power, 0);
		$display("power test done");
		report_and_stop;
	end
endmodule
